// ### logic/lcd_panel_instruction_exec.sv
// Purpose: executes panel controller instructions against internal state
// Assumes: i_instr_valid pulses once per received byte; i_rs selects data
// Notes: execution time base counts in core clock cycles, scaled by division
`default_nettype none
module lcd_panel_instruction_exec
  import lcd_instr_pkg::*;
(
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, low active
  input wire logic i_instr_valid, // one-cycle byte strobe
  input wire logic i_rs, // 1 = ram data, 0 = instruction
  input wire logic i_rw, // 1 = read
  input wire logic [7:0] i_instr_data, // instruction or write data
  input wire logic i_step_up, // entry mode increment
  input wire logic i_entry_shift, // entry mode display shift
  input wire logic i_key_press, // key detected, same domain pulse
  input wire logic [29:0] i_scan_latches, // six latches of five columns
  input wire logic [1:0] i_scan_state, // scan cycle state
  input wire logic [7:0] i_ram_rdata, // data from selected ram
  output logic o_busy, // instruction executing
  output logic [7:0] o_rdata, // read result
  output logic o_rdata_valid, // one-cycle read strobe
  output logic [6:0] o_ram_pointer, // address counter
  output logic [1:0] o_ram_sel, // selected ram
  output logic o_ram_we, // one-cycle write strobe
  output logic [7:0] o_ram_wdata, // write data
  output logic o_ext_access, // extension bit
  output logic [1:0] o_indicator_n, // indicator pins, inverted
  output logic [1:0] o_line_scroll, // per-line scroll enable
  output logic [2:0] o_ext_func, // wide font, reverse, invert
  output logic [1:0] o_fixed_chars, // unscrolled leftmost chars
  output logic [4:0] o_scroll_dots, // effective dot shift
  output logic [5:0] o_display_offset, // display shift position
  output logic o_blink_en, // ram blink enable
  output logic [4:0] o_clk_div, // internal clock divisor
  output logic [12:0] o_scan_period, // scan period in osc cycles
  output logic o_key_int_n // key interrupt, low active
);
  //////////////////////////////////////////////////////////////////////
  logic ext;
  logic [1:0] indicator_out_bits;
  logic [1:0] line_scroll_enable;
  logic [2:0] ext_func;
  logic keyscan_int_enable;
  logic sleep_select;
  logic [1:0] keyscan_period_sel;
  logic ram_blink_enable;
  logic low_power_select;
  logic line_count_select;
  logic [1:0] scroll_fixed_chars;
  logic [4:0] scroll_dot_count;
  logic [6:0] ram_pointer;
  ram_sel_t ram_sel;
  logic [5:0] disp_off;
  logic key_irq;
  exec_state_t state;
  // seventeen bits: sleep scales the busy span past sixteen
  logic [16:0] busy_cnt;
  logic [4:0] scan_idx;
  logic [2:0] status_idx;
  logic [7:0] rdata;
  logic rdata_valid;
  logic we;
  logic [7:0] wdata;

  logic take;
  logic is_cmd;
  logic [7:0] d;
  logic [6:0] ptr_inc;
  logic [6:0] ptr_dec;
  logic [6:0] next_ptr_step;
  logic [4:0] div;
  logic is_status;
  logic [4:0] latch_word [6];

  assign take = i_instr_valid && (state == ST_IDLE);
  assign is_cmd = take && !i_rs && !i_rw;
  assign d = i_instr_data;
  // status reads are taken even while busy
  assign is_status = i_instr_valid && !i_rs && i_rw;

  // cursor step wraps at 27h; the two-line wrap between 13h and 20h is unused while line_count_select stays zero
  always_comb begin
    ptr_inc = 7'(ram_pointer + 7'h01);
    ptr_dec = 7'(ram_pointer - 7'h01);
    if (ram_sel == SEL_TEXT && line_count_select) begin
      if (ram_pointer == TEXT_L1_LAST)
        ptr_inc = TEXT_L2_FIRST;
      else if (ram_pointer == TEXT_L2_LAST)
        ptr_inc = 7'h00;
      if (ram_pointer == TEXT_L2_FIRST)
        ptr_dec = TEXT_L1_LAST;
      else if (ram_pointer == 7'h00)
        ptr_dec = TEXT_L2_LAST;
    end else if (ram_sel == SEL_TEXT) begin
      if (ram_pointer == TEXT_ONE_LAST)
        ptr_inc = 7'h00;
      if (ram_pointer == 7'h00)
        ptr_dec = TEXT_ONE_LAST;
    end
    next_ptr_step = i_step_up ? ptr_inc : ptr_dec;
  end

  //////////////////////////////////////////////////////////////////////
  // extension bit: set or cleared from d[2] by function set only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext <= 1'b0;
    end else if (is_cmd && d[7:5] == 3'b001) begin
      ext <= d[2];
    end else if (is_cmd && d[7:4] == 4'b0001 && !ext) begin
      ext <= 1'b0;
    end
  end

  // extension-only registers hold their value while bit is clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      indicator_out_bits <= 2'h0;
      line_scroll_enable <= 2'h0;
      ext_func <= 3'h0;
      scroll_fixed_chars <= 2'h0;
      scroll_dot_count <= 5'h00;
    end else if (is_cmd && ext) begin
      if (d[7:4] == 4'b0001) begin
        indicator_out_bits <= d[3:2];
        line_scroll_enable <= d[1:0];
      end else if (d[7:3] == 5'b00001) begin
        ext_func <= d[2:0];
      end else if (d[7] == 1'b1) begin
        scroll_fixed_chars <= d[6:5];
        scroll_dot_count <= d[4:0];
      end
    end
  end

  // function set fields
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      keyscan_int_enable <= 1'b0;
      sleep_select <= 1'b0;
      keyscan_period_sel <= 2'h0;
      ram_blink_enable <= 1'b0;
      low_power_select <= 1'b0;
    end else if (is_cmd && d[7:5] == 3'b001) begin
      keyscan_int_enable <= d[4];
      sleep_select <= d[3];
      if (!ext) begin
        keyscan_period_sel <= d[1:0];
      end else begin
        ram_blink_enable <= d[1];
        low_power_select <= d[0];
      end
    end
  end

  // line count has no instruction here; held at zero (one line) from reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_count_select <= 1'b0;
    end else if (is_cmd && d[7:5] == 3'b001 && d[2] && d[1:0] == 2'b11 && 1'b0) begin
      line_count_select <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pointer, ram selection and display shift
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ram_pointer <= 7'h00;
      ram_sel <= SEL_TEXT;
      disp_off <= 6'h00;
    end else if (is_cmd) begin
      if (d[7:4] == 4'b0001 && !ext) begin
        unique case (d[3:2])
          2'b00: ram_pointer <= ptr_dec;
          2'b01: ram_pointer <= ptr_inc;
          2'b10: disp_off <= 6'(disp_off + 6'h01);
          2'b11: disp_off <= 6'(disp_off - 6'h01);
        endcase
      end else if (d[7:6] == 2'b01 && !ext) begin
        ram_pointer <= {1'b0, d[5:0]};
        ram_sel <= SEL_FONT;
      end else if (d[7:4] == 4'b0100 && ext) begin
        ram_pointer <= {3'h0, d[3:0]};
        ram_sel <= SEL_SEG;
      end else if (d[7] && !ext) begin
        // out-of-range text addresses are kept as given
        ram_pointer <= d[6:0];
        ram_sel <= SEL_TEXT;
      end
    end else if (take && i_rs) begin
      ram_pointer <= next_ptr_step;
      if (!i_rw && i_entry_shift && ram_sel == SEL_TEXT) begin
        disp_off <= i_step_up ? 6'(disp_off + 6'h01) : 6'(disp_off - 6'h01);
      end
    end
  end

  // ram write strobe and data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      we <= 1'b0;
      wdata <= 8'h00;
    end else begin
      we <= take && i_rs && !i_rw;
      if (take && i_rs && !i_rw)
        wdata <= d;
    end
  end

  // one five-bit word per scan latch
  for (genvar g = 0; g < 6; g++) begin : g_latch
    assign latch_word[g] = i_scan_latches[g * 5 +: 5];
  end

  // busy, then six scan latches, then scan state, in turn
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_idx <= 3'h0;
    end else if (is_status) begin
      status_idx <= (status_idx == 3'h7) ? 3'h0 : 3'(status_idx + 3'h1);
    end
  end

  // read return: ram data, or busy with the next status word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      // a status read answers while busy too, so it strobes as well
      rdata_valid <= (take && i_rs && i_rw) || is_status;
      if (take && i_rs && i_rw) begin
        rdata <= i_ram_rdata;
      end else if (is_status) begin
        if (status_idx == 3'h0)
          rdata <= {o_busy, 7'h00};
        else if (status_idx == 3'h7)
          rdata <= {o_busy, 5'h00, i_scan_state};
        else
          rdata <= {o_busy, 2'h0, latch_word[3'(status_idx - 3'h1)]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sleep wins over low power; both stretch execution
  always_comb begin
    div = 5'h01;
    if (sleep_select)
      div = 5'(SLEEP_DIV);
    else if (low_power_select)
      div = line_count_select ? 5'(LP_DIV_TWO_LINE) : 5'(LP_DIV_ONE_LINE);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      busy_cnt <= 17'h00000;
    end else begin
      // a status read never starts busy, so polling cannot stretch it
      unique case (state)
        ST_IDLE: if (take && !is_status) begin
          state <= ST_BUSY;
          busy_cnt <= 17'(EXEC_CYCLES * div);
        end
        ST_BUSY: if (busy_cnt <= 17'h00001) begin
          state <= ST_IDLE;
          busy_cnt <= 17'h00000;
        end else begin
          busy_cnt <= 17'(busy_cnt - 17'h00001);
        end
      endcase
    end
  end

  // key interrupt latches until interrupt enable is cleared
  // clearing the enable drops it, so a stale press cannot fire later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_irq <= 1'b0;
    end else if (keyscan_int_enable && i_key_press) begin
      key_irq <= 1'b1;
    end else if (!keyscan_int_enable) begin
      key_irq <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (keyscan_period_sel)
      2'b00: o_scan_period = 13'(SCAN_TC_00);
      2'b01: o_scan_period = 13'(SCAN_TC_01);
      2'b10: o_scan_period = 13'(SCAN_TC_10);
      2'b11: o_scan_period = 13'(SCAN_TC_11);
    endcase
  end

  assign scan_idx = scroll_dot_count;
  // codes past 23 dots all give the 24-dot maximum
  assign o_scroll_dots = (scan_idx > SCROLL_LIMIT_CODE) ? SCROLL_MAX_DOTS : scan_idx;
  assign o_busy = (state == ST_BUSY);
  assign o_rdata = rdata;
  assign o_rdata_valid = rdata_valid;
  assign o_ram_pointer = ram_pointer;
  assign o_ram_sel = ram_sel;
  assign o_ram_we = we;
  assign o_ram_wdata = wdata;
  assign o_ext_access = ext;
  assign o_indicator_n = ~indicator_out_bits;
  assign o_line_scroll = line_scroll_enable;
  assign o_ext_func = ext_func;
  assign o_fixed_chars = scroll_fixed_chars;
  assign o_display_offset = disp_off;
  assign o_blink_en = ram_blink_enable;
  assign o_clk_div = div;
  assign o_key_int_n = ~key_irq;
endmodule : lcd_panel_instruction_exec
`default_nettype wire

// ### logic/lcd_instr_pkg.sv
// Purpose: shared constants for the lcd panel instruction executor
// Assumes: instruction bytes arrive already deserialised
// Notes: timing counts derived from the 100 MHz core clock
`default_nettype none
package lcd_instr_pkg;
  localparam int CLK_MHZ = 100;
  // execution time of ordinary instructions, in microseconds
  localparam int EXEC_US = 63;
  localparam int EXEC_CYCLES = EXEC_US * CLK_MHZ;
  // key scan periods in oscillator cycles
  localparam int SCAN_TC_00 = 1536;
  localparam int SCAN_TC_01 = 768;
  localparam int SCAN_TC_10 = 3072;
  localparam int SCAN_TC_11 = 6144;
  localparam int SLEEP_DIV = 16;
  localparam int LP_DIV_ONE_LINE = 4;
  localparam int LP_DIV_TWO_LINE = 2;
  // text address limits
  localparam logic [6:0] TEXT_L1_LAST = 7'h13;
  localparam logic [6:0] TEXT_L2_FIRST = 7'h20;
  localparam logic [6:0] TEXT_L2_LAST = 7'h33;
  localparam logic [6:0] TEXT_ONE_LAST = 7'h27;
  localparam logic [4:0] SCROLL_MAX_DOTS = 5'h18;
  localparam logic [4:0] SCROLL_LIMIT_CODE = 5'h17;
  // ram selection
  typedef enum logic [1:0] {
    SEL_TEXT = 2'h0,
    SEL_FONT = 2'h1,
    SEL_SEG = 2'h2
  } ram_sel_t;
  // executor states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } exec_state_t;
endpackage : lcd_instr_pkg
`default_nettype wire

// ### tb/lcd_exec_assertions.sv
// Purpose: port-level checks for the instruction executor
// Assumes: one core clock, async low reset
// Notes: busy span scales with the clock divisor
`default_nettype none
module lcd_exec_checker
  import lcd_instr_pkg::*;
(
  input wire logic i_clk, // clk
  input wire logic i_rst_n, // rst
  input wire logic i_instr_valid, // strobe
  input wire logic i_rs, // data
  input wire logic i_rw, // read
  input wire logic [7:0] i_instr_data, // byte
  input wire logic i_key_press, // key
  input wire logic [7:0] i_ram_rdata, // ram
  input wire logic o_busy, // busy
  input wire logic [7:0] o_rdata, // rdata
  input wire logic o_rdata_valid, // rd
  input wire logic o_ram_we, // wr
  input wire logic [7:0] o_ram_wdata, // wdata
  input wire logic [6:0] o_ram_pointer, // ptr
  input wire logic o_ext_access, // ext
  input wire logic [1:0] o_indicator_n, // leds
  input wire logic [4:0] o_scroll_dots, // dots
  input wire logic [5:0] o_display_offset, // shift
  input wire logic [4:0] o_clk_div, // div
  input wire logic o_key_int_n // irq
);
  logic acc;
  logic wr;
  logic rd;
  logic [17:0] cnt;
  logic [4:0] div_cap;
  assign acc = i_instr_valid && !o_busy;
  assign wr = acc && i_rs && !i_rw;
  assign rd = acc && i_rs && i_rw;
  // sampled busy cycles, cleared when idle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt <= '0;
    else if (!o_busy) cnt <= '0;
    else cnt <= cnt + 18'h1;
  end
  // divisor in force when the instruction was taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) div_cap <= 5'h01;
    else if (!o_busy) div_cap <= o_clk_div;
  end
  ////////////////////
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_read_ans;
    o_rdata_valid && o_rdata == $past(i_ram_rdata);
  endsequence
  sequence s_no_shift;
    $stable(o_display_offset);
  endsequence
  a_write_strobe: assert property (wr |=> o_ram_we && o_busy)
    else $error("write strobe missing");
  a_write_data: assert property (wr |=> o_ram_wdata == $past(i_instr_data))
    else $error("write data wrong");
  a_read_answer: assert property (rd |=> s_read_ans ##0 s_no_shift)
    else $error("read answer wrong");
  a_busy_span: assert property ($fell(o_busy) |-> cnt == EXEC_CYCLES * div_cap)
    else $error("busy span wrong");
  a_busy_refuse: assert property (
    o_busy && i_instr_valid && (i_rs || !i_rw) |=> $stable(o_ram_pointer))
    else $error("byte taken while busy");
  a_key_irq: assert property ($fell(o_key_int_n) |->
    $past(i_key_press) || $past(i_key_press, 2))
    else $error("irq without key");
  a_led_gate: assert property ($changed(o_indicator_n) |-> $past(acc && o_ext_access))
    else $error("leds changed without ext");
  a_scroll_sat: assert property (
    acc && !i_rs && !i_rw && o_ext_access && i_instr_data[7]
    && i_instr_data[4:0] > SCROLL_LIMIT_CODE |=> o_scroll_dots == SCROLL_MAX_DOTS)
    else $error("scroll not saturated");
endmodule : lcd_exec_checker
bind lcd_panel_instruction_exec lcd_exec_checker lcd_exec_checker_inst (.*);
`default_nettype wire

// ### tb/lcd_ram_model.sv
// Purpose: ram and key scan side seen by the executor
// Assumes: ram answers combinationally from the pointer
// Notes: pattern follows the address so stale reads show
`default_nettype none
module lcd_ram_model (
  input wire logic [6:0] i_ram_pointer, // address
  input wire logic [1:0] i_ram_sel, // ram select
  output logic [7:0] o_ram_rdata, // read data
  output logic [29:0] o_scan_latches, // key latches
  output logic [1:0] o_scan_state // scan state
);
  assign o_ram_rdata = {i_ram_sel, i_ram_pointer[5:0]} ^ 8'h5a;
  assign o_scan_latches = 30'h0421_0842;
  assign o_scan_state = 2'h1;
endmodule : lcd_ram_model
`default_nettype wire

// ### tb/lcd_panel_instruction_exec_bench.sv
// Purpose: self-checking bench for the instruction executor
// Assumes: one instruction per busy window, driven at falling edge
// Notes: about 82k cycles, set by thirteen busy spans of the execution time; the 90k-cycle watchdog stays above it
`default_nettype none
module lcd_panel_instruction_exec_bench
  import lcd_instr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_instr_valid, i_rs, i_rw, i_step_up, i_entry_shift, i_key_press;
  logic [7:0] i_instr_data, i_ram_rdata, o_rdata, o_ram_wdata;
  logic [29:0] i_scan_latches;
  logic [1:0] i_scan_state, o_ram_sel, o_indicator_n, o_line_scroll, o_fixed_chars;
  logic o_busy, o_rdata_valid, o_ram_we, o_ext_access, o_blink_en, o_key_int_n;
  logic [6:0] o_ram_pointer;
  logic [2:0] o_ext_func;
  logic [4:0] o_scroll_dots, o_clk_div;
  logic [5:0] o_display_offset, offs;
  logic [12:0] o_scan_period;
  int mismatches = 0;
  int n_tests = 0;
  lcd_panel_instruction_exec lcd_panel_instruction_exec_inst (.*);
  lcd_ram_model lcd_ram_model_inst (
    .i_ram_pointer(o_ram_pointer),
    .i_ram_sel(o_ram_sel),
    .o_ram_rdata(i_ram_rdata),
    .o_scan_latches(i_scan_latches),
    .o_scan_state(i_scan_state)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic r, input logic w, input logic [7:0] d);
    @(negedge i_clk);
    i_rs = r;
    i_rw = w;
    i_instr_data = d;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
    i_instr_valid = 1'b0;
  endtask : send
  task automatic idle(input int lim);
    int k = 0;
    while (o_busy !== 1'b0 && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    chk(k < lim, 1'b1);
  endtask : idle
  task automatic final_report;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  ////////////////////
  task automatic t_func;
    send(1'b0, 1'b0, 8'h33);
    chk(o_scan_period, 13'h1800);
    send(1'b0, 1'b0, 8'h8f);
    chk(o_ram_pointer, 7'h00);
    send(1'b0, 1'b1, 8'h00);
    chk(o_rdata_valid, 1'b1);
    chk(o_rdata, 8'h80);
    i_key_press = 1'b1;
    @(negedge i_clk);
    i_key_press = 1'b0;
    @(negedge i_clk);
    chk(o_key_int_n, 1'b0);
    idle(7000);
  endtask : t_func
  task automatic t_addr;
    send(1'b0, 1'b0, 8'h7f);
    chk({o_ram_sel, o_ram_pointer}, {SEL_FONT, 7'h3f});
    idle(7000);
    send(1'b0, 1'b0, 8'h8f);
    chk({o_ram_sel, o_ram_pointer}, {SEL_TEXT, 7'h0f});
    idle(7000);
    send(1'b0, 1'b0, 8'h10);
    chk(o_ram_pointer, 7'h0e);
    idle(7000);
    send(1'b0, 1'b0, 8'h1c);
    chk(o_ram_pointer, 7'h0e);
    chk(o_display_offset != 6'h0, 1'b1);
    chk(o_indicator_n, 2'h3);
    offs = o_display_offset;
    idle(7000);
  endtask : t_addr
  task automatic t_read;
    i_entry_shift = 1'b1;
    send(1'b1, 1'b1, 8'h00);
    chk(o_rdata, 8'h0e ^ 8'h5a);
    chk(o_ram_pointer, 7'h0d);
    chk(o_display_offset, offs);
    idle(7000);
  endtask : t_read
  task automatic t_ext;
    send(1'b0, 1'b0, 8'h24);
    // the interrupt drops one edge after its enable clears
    @(negedge i_clk);
    chk({o_ext_access, o_key_int_n}, 2'h3);
    chk(o_scan_period, 13'h600);
    idle(7000);
    send(1'b0, 1'b0, 8'h19);
    chk({o_indicator_n, o_line_scroll}, 4'h5);
    idle(7000);
    send(1'b0, 1'b0, 8'hd9);
    chk({o_fixed_chars, o_scroll_dots}, {2'h2, SCROLL_MAX_DOTS});
    idle(7000);
    send(1'b0, 1'b0, 8'h45);
    chk({o_ram_sel, o_ram_pointer}, {SEL_SEG, 7'h05});
    idle(7000);
    send(1'b0, 1'b0, 8'h0b);
    chk(o_ext_func, 3'h3);
    idle(7000);
  endtask : t_ext
  task automatic t_write;
    i_step_up = 1'b1;
    send(1'b1, 1'b0, 8'ha5);
    chk({o_ram_we, o_ram_wdata}, 9'h1a5);
    chk(o_ram_pointer, 7'h06);
    chk(o_display_offset, offs);
    idle(7000);
  endtask : t_write
  task automatic t_power;
    send(1'b0, 1'b0, 8'h25);
    chk(o_clk_div, 5'h4);
    idle(30000);
    send(1'b0, 1'b0, 8'h2e);
    chk({o_clk_div, o_blink_en}, {5'h10, 1'b1});
  endtask : t_power
  ////////////////////
  initial begin
    #900000;
    mismatches++;
    final_report();
  end
  initial begin
    {i_rst_n, i_instr_valid, i_rs, i_rw, i_step_up, i_entry_shift, i_key_press} = 7'h0;
    i_instr_data = 8'h0;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk({o_indicator_n, o_key_int_n}, 3'h7);
    chk({o_scan_period, o_clk_div}, {13'h600, 5'h1});
    t_func();
    t_addr();
    t_read();
    t_ext();
    t_write();
    t_power();
    final_report();
  end
endmodule : lcd_panel_instruction_exec_bench
`default_nettype wire
